// *** include/alu_pkg.sv ***
// Shared types and constants for the rotate / subtract-with-borrow ALU slice
package alu_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int REG_IDX_W = 4;
    localparam int MSB_POS = 7;
    localparam int LSB_POS = 0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] HIGH_PAGE_ZERO = 8'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;

    // Operation selected by the decode stage
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_ROTATE_RIGHT_THROUGH_CARRY = 2'b01,
        OP_SUBTRACT_WITH_BORROW = 2'b10
    } op_type;

    // Condition flags
    typedef struct packed {
        logic carry;
        logic zero;
        logic overflow;
        logic negative;
    } flags_type;

    // Request from decode / memory stage
    typedef struct packed {
        op_type op;
        logic [3:0] dest_idx;
        logic [7:0] operand_a;
        logic op2_is_mem;
        logic [7:0] operand_b_reg;
        logic [7:0] direct_addr;
    } request_type;

    // Write-back toward the register file
    typedef struct packed {
        logic valid;
        logic [3:0] dest_idx;
        logic [7:0] data;
    } writeback_type;
endpackage : alu_pkg

// *** design/direct_addr_gen.sv ***
// Data memory address former for direct operands with page extension
`timescale 1ns/1ps
`default_nettype none
module direct_addr_gen (
    // Operand address
    input wire logic [7:0] direct_addr,
    // Page extension state
    input wire logic page_ext_en,
    input wire logic [7:0] index_high_byte,
    // Memory address
    output logic [15:0] mem_addr
);
    // High byte from index register only with extension on
    always_comb begin
        if (page_ext_en) begin
            mem_addr = {index_high_byte, direct_addr}; // see RULE7
        end else begin
            mem_addr = {alu_pkg::HIGH_PAGE_ZERO, direct_addr}; // see RULE7
        end
    end
endmodule : direct_addr_gen
`default_nettype wire

// *** design/alu_core_comb.sv ***
// Combinational result and flag computation for both operations
`timescale 1ns/1ps
`default_nettype none
module alu_core_comb (
    // Operation and operands
    input wire alu_pkg::op_type op,
    input wire logic [7:0] operand_a,
    input wire logic [7:0] operand_b,
    input wire alu_pkg::flags_type flags_in,
    // Results
    output logic [7:0] result,
    output alu_pkg::flags_type flags_out
);
    logic [8:0] sum;
    logic [7:0] inv_b;

    // Subtract as a + ~b + carry; carry out means no borrow
    assign inv_b = ~operand_b;
    assign sum = {1'b0, operand_a} + {1'b0, inv_b} + {8'h00, flags_in.carry}; // see RULE6

    // Result and flags per operation; untouched flags hold
    always_comb begin
        result = operand_a;
        flags_out = flags_in;
        case (op)
            alu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                result = {flags_in.carry, operand_a[7:1]}; // see RULE2
                flags_out.carry = operand_a[alu_pkg::LSB_POS]; // see RULE1
                flags_out.zero = (result == alu_pkg::ZERO_BYTE); // see RULE3
                flags_out.negative = result[alu_pkg::MSB_POS]; // see RULE4
            end
            alu_pkg::OP_SUBTRACT_WITH_BORROW: begin
                result = sum[7:0];
                flags_out.carry = sum[8]; // see RULE8
                // Signed overflow: same-sign inputs to the adder, result differs
                flags_out.overflow = (operand_a[7] == inv_b[7]) &&
                    (sum[7] != operand_a[7]); // see RULE9
                flags_out.negative = sum[7]; // see RULE10
                flags_out.zero = (sum[7:0] == alu_pkg::ZERO_BYTE); // see RULE10, RULE11
            end
            default: begin
                result = operand_a;
                flags_out = flags_in;
            end
        endcase
    end
endmodule : alu_core_comb
`default_nettype wire

// *** design/rotate_carry_subtract_borrow_alu.sv ***
// Top of the 8-bit rotate-through-carry / subtract-with-borrow ALU slice
// How it works
// RULE1: Rotate loads carry from old bit 0.
// RULE2: Rotate shifts right, old carry into bit 7.
// RULE3: Rotate sets zero flag on zero result.
// RULE4: Rotate sets negative from result bit 7.
// RULE5: Subtract takes register or direct-address operand.
// RULE6: Subtract is a plus inverted b plus carry.
// RULE7: Direct address high byte zero or index-high.
// RULE8: Subtract carry flag is adder carry out.
// RULE9: Subtract sets overflow on signed overflow.
// RULE10: Subtract sets negative and zero from result.
// RULE11: Zero flag reflects only latest byte result.
// RULE12: Flags and write-back commit in same cycle.
`timescale 1ns/1ps
`default_nettype none
module rotate_carry_subtract_borrow_alu (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Decode-stage request (first cycle: address issue)
    input wire logic REQ_VALID,
    input wire alu_pkg::request_type REQ,
    // Page extension state
    input wire logic PAGE_EXT_EN,
    input wire logic [7:0] INDEX_HIGH_BYTE,
    // Data memory read port
    output logic [15:0] MEM_ADDR,
    output logic MEM_RD,
    input wire logic [7:0] MEM_RDATA,
    // Execute / write-back results
    output alu_pkg::writeback_type WB,
    output alu_pkg::flags_type FLAGS
);
    alu_pkg::request_type exe_q;
    logic exe_valid_q;
    alu_pkg::flags_type flags_q;
    alu_pkg::flags_type flags_d;
    alu_pkg::writeback_type wb_q;
    logic [7:0] operand_b;
    logic [7:0] result;
    logic exe_is_rot;
    logic exe_is_sub;

    // Opcode tests shared by the memory strobe and the checks
    function automatic logic is_rotate(input alu_pkg::op_type op);
        return op == alu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY;
    endfunction : is_rotate

    function automatic logic is_subtract(input alu_pkg::op_type op);
        return op == alu_pkg::OP_SUBTRACT_WITH_BORROW;
    endfunction : is_subtract

    // Direct-address formation in the decode/memory stage
    direct_addr_gen u_addr (
        .direct_addr(REQ.direct_addr),
        .page_ext_en(PAGE_EXT_EN),
        .index_high_byte(INDEX_HIGH_BYTE),
        .mem_addr(MEM_ADDR)
    );

    // Memory read only for a direct-operand subtract
    assign MEM_RD = REQ_VALID && is_subtract(REQ.op) &&
        REQ.op2_is_mem; // see RULE5, RULE7

    // Pipeline register into the execute stage
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            exe_q <= '0;
            exe_valid_q <= 1'b0;
        end else begin
            exe_q <= REQ;
            exe_valid_q <= REQ_VALID && (REQ.op != alu_pkg::OP_NONE);
        end
    end

    // Second operand: memory data arrives a cycle after the address
    assign operand_b = exe_q.op2_is_mem ? MEM_RDATA : exe_q.operand_b_reg; // see RULE5

    // Decoded execute-stage operation, read only by the checks
    assign exe_is_rot = exe_valid_q && is_rotate(exe_q.op);
    assign exe_is_sub = exe_valid_q && is_subtract(exe_q.op);

    alu_core_comb u_core (
        .op(exe_valid_q ? exe_q.op : alu_pkg::OP_NONE),
        .operand_a(exe_q.operand_a),
        .operand_b(operand_b),
        .flags_in(flags_q),
        .result(result),
        .flags_out(flags_d)
    );

    // Flags commit in the execute cycle, next op sees them at once
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            flags_q <= alu_pkg::FLAGS_RESET;
        end else if (exe_valid_q) begin
            flags_q <= flags_d; // see RULE12
        end
    end

    // Write-back to the same register in that same cycle
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            wb_q <= '0;
        end else begin
            wb_q.valid <= exe_valid_q; // see RULE12
            wb_q.dest_idx <= exe_q.dest_idx; // see RULE2
            wb_q.data <= result;
        end
    end

    assign WB = wb_q;
    assign FLAGS = flags_q;

    // Checks
    a_rot_carry: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE1
        exe_valid_q && exe_q.op == alu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY
        |=> FLAGS.carry == $past(exe_q.operand_a[0])) // see RULE1
        else $error("rotate carry wrong");
    a_rot_result: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE2
        exe_valid_q && exe_q.op == alu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY
        |=> WB.data == {$past(flags_q.carry), $past(exe_q.operand_a[7:1])}) // see RULE2
        else $error("rotate result wrong");
    a_rot_zero: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE3
        exe_valid_q && exe_q.op == alu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY
        |=> FLAGS.zero == (WB.data == 8'h00)) // see RULE3
        else $error("rotate zero wrong");
    a_rot_neg: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE4
        exe_valid_q && exe_q.op == alu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY
        |=> FLAGS.negative == WB.data[7]) // see RULE4
        else $error("rotate negative wrong");
    a_mem_read: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE5
        MEM_RD |-> REQ.op2_is_mem) // see RULE5
        else $error("memory read without direct operand");
    a_sub_value: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE6
        exe_valid_q && exe_q.op == alu_pkg::OP_SUBTRACT_WITH_BORROW
        |=> WB.data == 8'($past(exe_q.operand_a) - $past(operand_b)
            - {7'h00, ~$past(flags_q.carry)})) // see RULE6
        else $error("subtract result wrong");
    a_page_zero: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE7
        MEM_RD && !PAGE_EXT_EN |-> MEM_ADDR[15:8] == 8'h00) // see RULE7
        else $error("high page not zero");
    a_page_ext: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE7
        MEM_RD && PAGE_EXT_EN |-> MEM_ADDR[15:8] == INDEX_HIGH_BYTE) // see RULE7
        else $error("high page not index high");
    a_sub_carry: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE8
        exe_valid_q && exe_q.op == alu_pkg::OP_SUBTRACT_WITH_BORROW
        |=> FLAGS.carry == ({1'b0, $past(exe_q.operand_a)} + {1'b0, ~$past(operand_b)}
            + {8'h00, $past(flags_q.carry)} > 9'h0FF)) // see RULE8
        else $error("subtract carry wrong");
    a_sub_ovf: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE9
        exe_valid_q && exe_q.op == alu_pkg::OP_SUBTRACT_WITH_BORROW
        |=> FLAGS.overflow == (($past(exe_q.operand_a[7]) != $past(operand_b[7]))
            && (WB.data[7] != $past(exe_q.operand_a[7])))) // see RULE9
        else $error("subtract overflow wrong");
    a_sub_nz: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE10, RULE11
        exe_valid_q && exe_q.op == alu_pkg::OP_SUBTRACT_WITH_BORROW
        |=> FLAGS.negative == WB.data[7] && FLAGS.zero == (WB.data == 8'h00)) // see RULE10, RULE11
        else $error("subtract negative or zero wrong");
    a_commit_same: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // see RULE12
        !exe_valid_q |=> !WB.valid && FLAGS == $past(flags_q)) // see RULE12
        else $error("commit without instruction");

    // Further checks, mostly independent of the adder expression
    // Write-back goes to the register named by the instruction
    a_wb_dest_same: assert property ( // see RULE2
        @(posedge SYS_CLK) disable iff (!RSTN)
        exe_valid_q
        |=> WB.dest_idx == $past(exe_q.dest_idx))
        else $error("write-back destination wrong");

    // One write-back pulse per executed instruction
    a_wb_follows: assert property ( // see RULE12
        @(posedge SYS_CLK) disable iff (!RSTN)
        1'b1
        |-> WB.valid == $past(exe_valid_q))
        else $error("write-back pulse misplaced");

    // Only subtract touches the overflow flag
    a_ovf_only_sub: assert property ( // see RULE12
        @(posedge SYS_CLK) disable iff (!RSTN)
        exe_valid_q && !exe_is_sub
        |=> FLAGS.overflow == $past(flags_q.overflow))
        else $error("overflow changed outside subtract");

    // Rotate works on a register and never reads memory
    a_rot_no_mem: assert property ( // see RULE5
        @(posedge SYS_CLK) disable iff (!RSTN)
        REQ_VALID && is_rotate(REQ.op)
        |-> !MEM_RD)
        else $error("rotate read memory");

    // Register-operand subtract never reads memory
    a_sub_reg_no_mem: assert property ( // see RULE5
        @(posedge SYS_CLK) disable iff (!RSTN)
        REQ_VALID && is_subtract(REQ.op) && !REQ.op2_is_mem
        |-> !MEM_RD)
        else $error("register subtract read memory");

    // Low address byte is the direct operand itself
    a_addr_low: assert property ( // see RULE7
        @(posedge SYS_CLK) disable iff (!RSTN)
        MEM_RD
        |-> MEM_ADDR[7:0] == REQ.direct_addr)
        else $error("low address byte wrong");

    // With extension off the page byte is zero whatever the index holds
    a_ext_off_zero: assert property ( // see RULE7
        @(posedge SYS_CLK) disable iff (!RSTN)
        !PAGE_EXT_EN
        |-> MEM_ADDR[15:8] == 8'h00)
        else $error("page byte not zero with extension off");

    // Memory operand comes from the read data of the previous cycle
    a_sub_mem_operand: assert property ( // see RULE5
        @(posedge SYS_CLK) disable iff (!RSTN)
        exe_is_sub && exe_q.op2_is_mem
        |=> WB.data == 8'($past(exe_q.operand_a) + ~$past(MEM_RDATA)
            + {7'h00, $past(flags_q.carry)}))
        else $error("memory operand not used");

    // Register operand comes from the request
    a_sub_reg_operand: assert property ( // see RULE5
        @(posedge SYS_CLK) disable iff (!RSTN)
        exe_is_sub && !exe_q.op2_is_mem
        |=> WB.data == 8'($past(exe_q.operand_a) + ~$past(exe_q.operand_b_reg)
            + {7'h00, $past(flags_q.carry)}))
        else $error("register operand not used");

    // Carry set gives the plain difference
    a_sub_plain_diff: assert property ( // see RULE6
        @(posedge SYS_CLK) disable iff (!RSTN)
        exe_is_sub && flags_q.carry
        |=> WB.data == 8'($past(exe_q.operand_a) - $past(operand_b)))
        else $error("difference wrong with carry set");

    // Carry clear gives the difference less one
    a_sub_less_one: assert property ( // see RULE6
        @(posedge SYS_CLK) disable iff (!RSTN)
        exe_is_sub && !flags_q.carry
        |=> WB.data == 8'($past(exe_q.operand_a) - $past(operand_b) - 8'h01))
        else $error("difference wrong with carry clear");

    // Equal operands with carry in: no borrow and a zero byte
    a_sub_no_borrow: assert property ( // see RULE8, RULE10
        @(posedge SYS_CLK) disable iff (!RSTN)
        exe_is_sub && exe_q.operand_a == operand_b && flags_q.carry
        |=> FLAGS.carry && FLAGS.zero)
        else $error("equal operands gave borrow");

    // Zero minus one borrows and turns negative
    a_sub_neg_borrow: assert property ( // see RULE8, RULE10
        @(posedge SYS_CLK) disable iff (!RSTN)
        exe_is_sub && exe_q.operand_a == 8'h00 && operand_b == 8'h01 && flags_q.carry
        |=> !FLAGS.carry && FLAGS.negative)
        else $error("zero minus one flags wrong");

    // In a chain the zero flag follows only the last byte
    a_zero_latest: assert property ( // see RULE11
        @(posedge SYS_CLK) disable iff (!RSTN)
        exe_is_sub ##1 exe_is_sub
        |=> FLAGS.zero == (WB.data == 8'h00))
        else $error("zero flag not from last byte");

    // Rotate of one with carry clear: zero result, carry out
    a_rot_zero_carry: assert property ( // see RULE1, RULE3
        @(posedge SYS_CLK) disable iff (!RSTN)
        exe_is_rot && exe_q.operand_a == 8'h01 && !flags_q.carry
        |=> FLAGS.zero && FLAGS.carry)
        else $error("rotate of one flags wrong");

    // Rotated-in carry becomes the sign of the result
    a_rot_neg_carry: assert property ( // see RULE4
        @(posedge SYS_CLK) disable iff (!RSTN)
        exe_is_rot
        |=> FLAGS.negative == $past(flags_q.carry))
        else $error("rotate negative not old carry");

    // Flags never move without a write-back beside them
    a_flags_with_wb: assert property ( // see RULE12
        @(posedge SYS_CLK) disable iff (!RSTN)
        $changed(FLAGS)
        |-> WB.valid)
        else $error("flags changed without write-back");

    // A request with no operation produces no write-back
    a_none_no_wb: assert property ( // see RULE12
        @(posedge SYS_CLK) disable iff (!RSTN)
        REQ_VALID && REQ.op == alu_pkg::OP_NONE
        |-> ##2 !WB.valid)
        else $error("write-back for no operation");

    c_rotate: cover property (@(posedge SYS_CLK)
        exe_valid_q && exe_q.op == alu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY);
    c_sub_reg: cover property (@(posedge SYS_CLK)
        exe_valid_q && exe_q.op == alu_pkg::OP_SUBTRACT_WITH_BORROW && !exe_q.op2_is_mem);
    c_sub_mem_ext: cover property (@(posedge SYS_CLK) MEM_RD && PAGE_EXT_EN);
    c_chain: cover property (@(posedge SYS_CLK)
        exe_valid_q && exe_q.op == alu_pkg::OP_SUBTRACT_WITH_BORROW ##1
        exe_valid_q && exe_q.op == alu_pkg::OP_SUBTRACT_WITH_BORROW);
endmodule : rotate_carry_subtract_borrow_alu
`default_nettype wire

// *** testbench/data_memory_model.sv ***
// Behavioural data memory answering direct-address reads one cycle later
`timescale 1ns/1ps
`default_nettype none
module data_memory_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Read port
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    output var logic [7:0] rdata
);
    // Content is a fold of both address bytes, so a wrong page byte shows in the data
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata <= 8'h5A;
        end else if (mem_rd) begin
            rdata <= mem_addr[7:0] + mem_addr[15:8] + 8'h11;
        end else begin
            rdata <= ~rdata; // Idle bus toggles so stale data is never mistaken for an answer
        end
    end
endmodule : data_memory_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the rotate / subtract-with-borrow ALU slice
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic SYS_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic REQ_VALID = 1'b0;
    alu_pkg::request_type REQ = '0;
    logic PAGE_EXT_EN = 1'b0;
    logic [7:0] INDEX_HIGH_BYTE = 8'h00;
    logic [15:0] MEM_ADDR;
    logic MEM_RD;
    logic [7:0] MEM_RDATA;
    alu_pkg::writeback_type WB;
    alu_pkg::flags_type FLAGS;
    int fails = 0;
    int samples_checked = 0;
    logic [3:0] exp_f = 4'h0; // Expected carry, zero, overflow, negative
    localparam alu_pkg::op_type ROT = alu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY;
    localparam alu_pkg::op_type SUB = alu_pkg::OP_SUBTRACT_WITH_BORROW;
    // Design and memory partner
    rotate_carry_subtract_borrow_alu dut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .REQ_VALID(REQ_VALID),
        .REQ(REQ), .PAGE_EXT_EN(PAGE_EXT_EN), .INDEX_HIGH_BYTE(INDEX_HIGH_BYTE),
        .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_RDATA(MEM_RDATA), .WB(WB), .FLAGS(FLAGS));
    data_memory_model mem (.clk(SYS_CLK), .rstn(RSTN), .mem_addr(MEM_ADDR), .mem_rd(MEM_RD),
        .rdata(MEM_RDATA));
    // 100 MHz clock
    initial begin
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One instruction: expectation first, then request, then fixed two-edge answer
    task do_op(input alu_pkg::op_type op, input logic [7:0] a, input logic is_mem,
               input logic [7:0] b, input logic [7:0] da, input logic ext, input logic [7:0] ihb);
        logic [15:0] addr;
        logic [7:0] opb;
        logic [8:0] sum;
        logic [7:0] res;
        addr = {ext ? ihb : 8'h00, da};
        opb = is_mem ? addr[7:0] + addr[15:8] + 8'h11 : b;
        sum = {1'b0, a} + {1'b0, ~opb} + {8'h00, exp_f[3]};
        if (op == ROT) begin
            res = {exp_f[3], a[7:1]};
            exp_f[3] = a[0];
        end else begin
            res = sum[7:0];
            exp_f[1] = (a[7] != opb[7]) && (res[7] != a[7]);
            exp_f[3] = sum[8];
        end
        exp_f[2] = (res == 8'h00);
        exp_f[0] = res[7];
        @(posedge SYS_CLK);
        REQ_VALID <= 1'b1;
        REQ <= '{op: op, dest_idx: da[3:0], operand_a: a, op2_is_mem: is_mem,
                 operand_b_reg: b, direct_addr: da};
        PAGE_EXT_EN <= ext;
        INDEX_HIGH_BYTE <= ihb;
        #1 check("mem_rd", MEM_RD, op == SUB && is_mem);
        if (is_mem) check("mem_addr", MEM_ADDR, addr);
        @(posedge SYS_CLK);
        REQ_VALID <= 1'b0;
        #1 check("wb_early", WB.valid, 1'b0);
        @(posedge SYS_CLK);
        #1 check("wb_valid", WB.valid, 1'b1);
        check("wb_data", WB.data, res);
        check("wb_dest", WB.dest_idx, da[3:0]);
        check("flags", FLAGS, exp_f);
        @(posedge SYS_CLK);
        #1 check("wb_pulse", WB.valid, 1'b0);
    endtask : do_op
    task t_rotate;
        do_op(ROT, 8'hA5, 1'b0, 8'h00, 8'h02, 1'b0, 8'h00);
        do_op(ROT, 8'h00, 1'b0, 8'h00, 8'h03, 1'b0, 8'h00);
        do_op(ROT, 8'h01, 1'b0, 8'h00, 8'h04, 1'b0, 8'h00);
        $display("rotate test done");
    endtask : t_rotate
    task t_sub_reg;
        do_op(SUB, 8'h50, 1'b0, 8'h20, 8'h05, 1'b0, 8'h00);
        do_op(SUB, 8'h80, 1'b0, 8'h01, 8'h06, 1'b0, 8'h00);
        do_op(SUB, 8'h00, 1'b0, 8'h01, 8'h07, 1'b0, 8'h00);
        do_op(SUB, 8'h05, 1'b0, 8'h04, 8'h08, 1'b0, 8'h00);
        do_op(SUB, 8'h33, 1'b0, 8'h33, 8'h09, 1'b0, 8'h00);
        $display("subtract register test done");
    endtask : t_sub_reg
    task t_sub_mem;
        do_op(SUB, 8'h90, 1'b1, 8'hFF, 8'h80, 1'b0, 8'h3C);
        do_op(SUB, 8'h10, 1'b1, 8'h00, 8'h80, 1'b1, 8'h3C);
        $display("subtract memory test done");
    endtask : t_sub_mem
    task t_chain;
        do_op(SUB, 8'h00, 1'b0, 8'h01, 8'h00, 1'b0, 8'h00);
        do_op(SUB, 8'h01, 1'b0, 8'h00, 8'h01, 1'b0, 8'h00);
        $display("chain test done");
    endtask : t_chain
    // Valid request with no operation must give no write-back pulse, no flag change and no memory read
    task t_none;
        @(posedge SYS_CLK);
        REQ_VALID <= 1'b1;
        REQ <= '{op: alu_pkg::OP_NONE, dest_idx: 4'h9, operand_a: 8'h00, op2_is_mem: 1'b1,
                 operand_b_reg: 8'h00, direct_addr: 8'h00};
        repeat (3) begin
            @(posedge SYS_CLK);
            #1 check("none_wb", WB.valid, 1'b0);
            check("none_flags", FLAGS, exp_f);
            check("none_rd", MEM_RD, 1'b0);
        end
        @(posedge SYS_CLK);
        REQ_VALID <= 1'b0;
        $display("no-operation test done");
    endtask : t_none
    task summarize;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    // Main sequence
    initial begin
        repeat (10) @(posedge SYS_CLK);
        RSTN <= 1'b1;
        #1 check("rst_wb", WB.valid, 1'b0);
        check("rst_flags", FLAGS, alu_pkg::FLAGS_RESET);
        t_rotate();
        t_sub_reg();
        t_sub_mem();
        t_chain();
        t_none();
        summarize();
    end
    // Watchdog well beyond the 63 cycles the tests need
    initial begin
        repeat (5000) @(posedge SYS_CLK);
        fails++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
